// file: core/mis_sequencer.sv
// Instruction sequencer: phases, PC, return stack, ALU control, APB
//
// Functional notes
// - Four phase clocks make one instruction cycle.
// - PC increments and fetch begins in phase one.
// - Fetch overlaps execute; PC changes cost a cycle.
// - PC is 11 bits; only low byte accessible.
// - Jumps, calls, interrupts, reset load the PC.
// - Taken skip discards prefetch, runs dummy cycle.
// - Low byte write jumps within page, adds dummy.
// - Stack holds PCs only, invisible to software.
// - Call/interrupt push PC; returns pop it.
// - Reset empties the stack.
// - Full stack holds interrupt pending until return.
// - Call on full stack loses oldest entry.
// - Eight-bit ALU writes dest and status flags.
// - Add/sub with carry, decimal adjust, logic ops.
// - Rotates, inc/dec, jumps, calls, skips.
// - Program memory is 2K words of 16 bits.
// - Reset starts execution at address zero.
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module mis_sequencer #(
    parameter int STACK_DEPTH = 8, // Must be a power of two
    parameter int PMEM_WORDS = mis_pkg::PMEM_WORDS
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [mis_pkg::APB_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [mis_pkg::PC_W-1:0] o_pmem_addr,
    input wire logic [mis_pkg::INSTR_W-1:0] i_pmem_data,
    output logic [7:0] o_dmem_addr,
    output logic [7:0] o_dmem_wdata,
    output logic o_dmem_we,
    input wire logic [7:0] i_dmem_rdata,
    input wire logic i_int_req,
    output logic o_int_ack,
    output logic [3:0] o_instruction_phase_clocks
);

    localparam int SP_W = $clog2(STACK_DEPTH);
    localparam int CNT_W = $clog2(STACK_DEPTH + 1);

    // Phase and program counter state
    mis_pkg::mis_phase_e phase; // Current instruction phase
    mis_pkg::mis_phase_e next_phase;
    logic [10:0] pc; // Address of the next fetch
    logic [10:0] exec_addr; // Address of the executing word
    mis_pkg::mis_instr_s ir; // Executing instruction

    // Datapath state
    logic [7:0] acc; // Accumulator
    logic [7:0] operand; // Memory operand caught in phase three
    mis_pkg::mis_flags_s flags; // Carry and zero

    // Return stack, invisible to software
    logic [10:0] stack_mem [STACK_DEPTH];
    logic [SP_W-1:0] stack_top; // Next free slot
    logic [CNT_W-1:0] stack_count; // Levels in use
    logic stack_full;
    logic [10:0] stack_pop_val;

    // Interrupt and control state
    logic irq_flag; // Sticky request
    logic gie; // Global interrupt enable
    logic run; // Sequencer runs when high
    logic pcl_pend; // Bus write to the low PC byte waiting
    logic [7:0] pcl_val;

    // Decode results
    mis_pkg::mis_alu_op_e alu_op;
    logic [7:0] alu_mem;
    logic [7:0] alu_result;
    mis_pkg::mis_flags_s alu_flags;
    logic exec; // Last phase of a running cycle
    logic wr_acc;
    logic wr_mem;
    logic wr_flags;
    logic wr_pcl; // Instruction writes the low PC byte
    logic skip_taken;
    logic is_branch;
    logic is_call;
    logic is_pop;
    logic instr_redirect;
    logic take_irq;
    logic take_pcl;
    logic redirect;

    // APB decode
    logic apb_setup;
    logic apb_write;
    logic apb_mapped;

    // Map an instruction to its ALU function
    function automatic mis_pkg::mis_alu_op_e decode_alu(
        input mis_pkg::mis_instr_s ins
    );
        mis_pkg::mis_alu_op_e r;
        r = mis_pkg::ALU_PASS_M;
        case (ins.op)
            mis_pkg::OP_ADD: r = mis_pkg::ALU_ADD;
            mis_pkg::OP_ADC: r = mis_pkg::ALU_ADC;
            mis_pkg::OP_SUB: r = mis_pkg::ALU_SUB;
            mis_pkg::OP_SBC: r = mis_pkg::ALU_SBC;
            mis_pkg::OP_AND: r = mis_pkg::ALU_AND;
            mis_pkg::OP_OR: r = mis_pkg::ALU_OR;
            mis_pkg::OP_XOR: r = mis_pkg::ALU_XOR;
            mis_pkg::OP_CPL: r = mis_pkg::ALU_CPL;
            mis_pkg::OP_ROT: begin
                case (ins.aux[1:0])
                    2'h0: r = mis_pkg::ALU_RR;
                    2'h1: r = mis_pkg::ALU_RRC;
                    2'h2: r = mis_pkg::ALU_RL;
                    default: r = mis_pkg::ALU_RLC;
                endcase
            end
            mis_pkg::OP_INCDEC: begin
                r = ins.aux[0] ? mis_pkg::ALU_DEC : mis_pkg::ALU_INC;
            end
            mis_pkg::OP_SKIP: begin
                r = (ins.aux == mis_pkg::SKIP_DEC_ZERO) ?
                    mis_pkg::ALU_DEC : mis_pkg::ALU_INC;
            end
            mis_pkg::OP_MISC: begin
                if (ins.aux == mis_pkg::MISC_DAA) begin
                    r = mis_pkg::ALU_DAA;
                end
            end
            mis_pkg::OP_IMM_STORE: begin
                r = ins.dest_mem ? mis_pkg::ALU_PASS_A : mis_pkg::ALU_PASS_M;
            end
            default: r = mis_pkg::ALU_PASS_M;
        endcase
        return r;
    endfunction

    // One-hot view of a phase for the phase clock outputs
    function automatic logic [3:0] phase_onehot(
        input mis_pkg::mis_phase_e p
    );
        return 4'h1 << p;
    endfunction

    // Shared ALU
    mis_alu u_alu (
        .i_op(alu_op),
        .i_acc(acc),
        .i_mem(alu_mem),
        .i_flags(flags),
        .o_result(alu_result),
        .o_flags(alu_flags)
    );

    // Phase walk; a halted core parks on its current phase
    always_comb begin
        case (phase)
            mis_pkg::PH_T1: next_phase = mis_pkg::PH_T2;
            mis_pkg::PH_T2: next_phase = mis_pkg::PH_T3;
            mis_pkg::PH_T3: next_phase = mis_pkg::PH_T4;
            mis_pkg::PH_T4: next_phase = mis_pkg::PH_T1;
            default: next_phase = mis_pkg::PH_T1;
        endcase
        if (!run) begin
            next_phase = phase;
        end
    end

    assign exec = run && (phase == mis_pkg::PH_T4);
    assign stack_full = (stack_count == CNT_W'(STACK_DEPTH));
    assign stack_pop_val = stack_mem[stack_top - SP_W'(1)];

    // Instruction decode and redirect decision for phase four
    always_comb begin
        alu_op = decode_alu(ir);
        alu_mem = (ir.op == mis_pkg::OP_IMM_STORE) ? ir.addr : operand;
        wr_acc = 1'b0;
        wr_mem = 1'b0;
        wr_flags = 1'b0;
        skip_taken = 1'b0;
        is_branch = 1'b0;
        is_call = 1'b0;
        is_pop = 1'b0;
        case (ir.op)
            mis_pkg::OP_ADD, mis_pkg::OP_ADC, mis_pkg::OP_SUB,
            mis_pkg::OP_SBC, mis_pkg::OP_AND, mis_pkg::OP_OR,
            mis_pkg::OP_XOR, mis_pkg::OP_CPL, mis_pkg::OP_ROT,
            mis_pkg::OP_INCDEC: begin
                // Result to memory or accumulator
                wr_mem = ir.dest_mem;
                wr_acc = !ir.dest_mem;
                wr_flags = 1'b1;
            end
            mis_pkg::OP_MISC: begin
                wr_mem = (ir.aux == mis_pkg::MISC_DAA) && ir.dest_mem;
                wr_acc = (ir.aux == mis_pkg::MISC_DAA) && !ir.dest_mem;
                wr_flags = (ir.aux == mis_pkg::MISC_DAA);
                is_pop = (ir.aux == mis_pkg::MISC_SUB_EXIT) ||
                    (ir.aux == mis_pkg::MISC_INT_EXIT);
            end
            mis_pkg::OP_SKIP: begin
                // Counting skips write back; plain tests do not
                case (ir.aux)
                    mis_pkg::SKIP_ZERO: skip_taken = (operand == 8'h00);
                    mis_pkg::SKIP_NONZERO: skip_taken = (operand != 8'h00);
                    mis_pkg::SKIP_INC_ZERO, mis_pkg::SKIP_DEC_ZERO: begin
                        skip_taken = (alu_result == 8'h00);
                        wr_mem = ir.dest_mem;
                        wr_acc = !ir.dest_mem;
                    end
                    default: skip_taken = 1'b0;
                endcase
            end
            mis_pkg::OP_BRANCH: is_branch = 1'b1;
            mis_pkg::OP_CALL: is_call = 1'b1;
            mis_pkg::OP_IMM_STORE: begin
                wr_mem = ir.dest_mem;
                wr_acc = !ir.dest_mem;
            end
            mis_pkg::OP_LOAD: wr_acc = 1'b1;
            default: wr_acc = 1'b0;
        endcase
        wr_pcl = wr_mem && (ir.addr == mis_pkg::PCL_DADDR);
        instr_redirect = is_branch || is_call || is_pop || wr_pcl ||
            skip_taken;
        // Acknowledge only with a free stack level
        take_irq = irq_flag && gie && !stack_full && !instr_redirect;
        take_pcl = pcl_pend && !instr_redirect && !take_irq;
        redirect = instr_redirect || take_irq || take_pcl;
    end

    // Phase counter and phase clock outputs
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            phase <= mis_pkg::PH_T1;
            o_instruction_phase_clocks <= 4'h1;
        end else begin
            phase <= next_phase;
            o_instruction_phase_clocks <= phase_onehot(next_phase);
        end
    end

    // Program counter: fetch in phase one, reload in phase four
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pc <= mis_pkg::RESET_VECTOR;
            o_pmem_addr <= mis_pkg::RESET_VECTOR;
        end else if (run && phase == mis_pkg::PH_T1) begin
            o_pmem_addr <= pc;
            pc <= pc + 11'h001;
        end else if (exec) begin
            // Reloads replace the increment
            if (is_branch || is_call) begin
                pc <= {ir.aux, ir.addr};
            end else if (is_pop) begin
                pc <= stack_pop_val;
            end else if (wr_pcl) begin
                pc <= {exec_addr[10:8], alu_result};
            end else if (take_irq) begin
                pc <= mis_pkg::INT_VECTOR;
            end else if (take_pcl) begin
                pc <= {exec_addr[10:8], pcl_val};
            end
        end
    end

    // Instruction register; a redirect turns the prefetch into a dummy
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ir <= mis_pkg::NOP_INSTR;
            exec_addr <= mis_pkg::RESET_VECTOR;
        end else if (exec) begin
            ir <= redirect ? mis_pkg::NOP_INSTR : i_pmem_data;
            exec_addr <= o_pmem_addr;
        end
    end

    // Data memory: address in phase two, operand in three, write in one
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_dmem_addr <= 8'h00;
            o_dmem_wdata <= 8'h00;
            o_dmem_we <= 1'b0;
            operand <= 8'h00;
        end else begin
            o_dmem_we <= exec && wr_mem && !wr_pcl;
            if (run && phase == mis_pkg::PH_T1) begin
                o_dmem_addr <= ir.addr;
            end
            if (run && phase == mis_pkg::PH_T3) begin
                // The low PC byte lives here, not in memory
                operand <= (ir.addr == mis_pkg::PCL_DADDR) ?
                    exec_addr[7:0] : i_dmem_rdata;
            end
            if (exec && wr_mem) begin
                o_dmem_wdata <= alu_result;
            end
        end
    end

    // Accumulator and status flags
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            acc <= 8'h00;
            flags <= '0;
        end else if (exec) begin
            if (wr_acc) begin
                acc <= alu_result;
            end
            if (wr_flags) begin
                flags <= alu_flags;
            end
        end
    end

    // Return stack; a push when full overwrites the oldest level
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            stack_top <= '0;
            stack_count <= '0;
        end else if (exec && (is_call || take_irq)) begin
            stack_mem[stack_top] <= o_pmem_addr;
            stack_top <= stack_top + SP_W'(1);
            if (!stack_full) begin
                stack_count <= stack_count + CNT_W'(1);
            end
        end else if (exec && is_pop) begin
            stack_top <= stack_top - SP_W'(1);
            if (stack_count != '0) begin
                stack_count <= stack_count - CNT_W'(1);
            end
        end
    end

    // Interrupt request flag; a new request beats the acknowledge clear
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            irq_flag <= 1'b0;
            o_int_ack <= 1'b0;
        end else begin
            irq_flag <= i_int_req || (irq_flag && !(exec && take_irq));
            o_int_ack <= exec && take_irq;
        end
    end

    // Control bits; hardware events win over a same-cycle bus write
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            run <= mis_pkg::CTRL_RESET[mis_pkg::CTRL_RUN_BIT];
            gie <= mis_pkg::CTRL_RESET[mis_pkg::CTRL_GIE_BIT];
        end else begin
            if (apb_write && i_paddr == mis_pkg::REG_CTRL) begin
                run <= i_pwdata[mis_pkg::CTRL_RUN_BIT];
                gie <= i_pwdata[mis_pkg::CTRL_GIE_BIT];
            end
            if (exec && take_irq) begin
                gie <= 1'b0; // No nesting until the exit
            end else if (exec && is_pop &&
                ir.aux == mis_pkg::MISC_INT_EXIT) begin
                gie <= 1'b1;
            end
        end
    end

    // Bus write of the low PC byte waits for a phase four with no other redirect
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pcl_pend <= 1'b0;
            pcl_val <= 8'h00;
        end else if (apb_write && i_paddr == mis_pkg::REG_PCL) begin
            pcl_pend <= 1'b1;
            pcl_val <= i_pwdata[7:0];
        end else if (exec && take_pcl) begin
            pcl_pend <= 1'b0;
        end
    end

    // APB slave: no wait state, yet read data comes from a flop
    assign apb_setup = i_psel && !i_penable;
    assign apb_write = i_psel && i_penable && o_pready && i_pwrite &&
        apb_mapped;
    assign apb_mapped = (i_paddr == mis_pkg::REG_PCL) ||
        (i_paddr == mis_pkg::REG_CTRL) || (i_paddr == mis_pkg::REG_STATUS);

    // Read data and error are settled in the setup cycle
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h00000000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= apb_setup;
            if (apb_setup) begin
                o_pslverr <= !apb_mapped;
                o_prdata <= 32'h00000000;
                // The stack and its pointer have no address at all
                case (i_paddr)
                    mis_pkg::REG_PCL: o_prdata[7:0] <= exec_addr[7:0];
                    mis_pkg::REG_CTRL: begin
                        o_prdata[mis_pkg::CTRL_RUN_BIT] <= run;
                        o_prdata[mis_pkg::CTRL_GIE_BIT] <= gie;
                    end
                    mis_pkg::REG_STATUS: begin
                        o_prdata[mis_pkg::STAT_CARRY_BIT] <= flags.carry;
                        o_prdata[mis_pkg::STAT_ZERO_BIT] <= flags.zero;
                        o_prdata[mis_pkg::STAT_IRQ_BIT] <= irq_flag;
                        o_prdata[mis_pkg::STAT_ACC_LSB +: 8] <= acc;
                    end
                    default: o_prdata <= 32'h00000000;
                endcase
            end else begin
                // Error stands in the access cycle only
                o_pslverr <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// file: core/mis_pkg.sv
// Shared constants and types for the instruction sequencer core
package mis_pkg;

    // Datapath widths
    localparam int PC_W = 11;
    localparam int DATA_W = 8;
    localparam int INSTR_W = 16;
    localparam int PMEM_WORDS = 2048;

    // Program counter reset and interrupt targets
    localparam logic [10:0] RESET_VECTOR = 11'h000;
    localparam logic [10:0] INT_VECTOR = 11'h004;

    // Data-space address at which the low PC byte sits
    localparam logic [7:0] PCL_DADDR = 8'h06;

    // APB register map, byte addresses
    localparam int APB_ADDR_W = 4;
    localparam logic [3:0] REG_PCL = 4'h0;
    localparam logic [3:0] REG_CTRL = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;

    // Control register fields and reset value
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_GIE_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;

    // Status register fields
    localparam int STAT_CARRY_BIT = 0;
    localparam int STAT_ZERO_BIT = 1;
    localparam int STAT_IRQ_BIT = 2;
    localparam int STAT_ACC_LSB = 8;

    // Major opcodes
    localparam logic [3:0] OP_MISC = 4'h0;
    localparam logic [3:0] OP_ADD = 4'h1;
    localparam logic [3:0] OP_ADC = 4'h2;
    localparam logic [3:0] OP_SUB = 4'h3;
    localparam logic [3:0] OP_SBC = 4'h4;
    localparam logic [3:0] OP_AND = 4'h5;
    localparam logic [3:0] OP_OR = 4'h6;
    localparam logic [3:0] OP_XOR = 4'h7;
    localparam logic [3:0] OP_CPL = 4'h8;
    localparam logic [3:0] OP_ROT = 4'h9;
    localparam logic [3:0] OP_INCDEC = 4'hA;
    localparam logic [3:0] OP_SKIP = 4'hB;
    localparam logic [3:0] OP_BRANCH = 4'hC;
    localparam logic [3:0] OP_CALL = 4'hD;
    localparam logic [3:0] OP_IMM_STORE = 4'hE;
    localparam logic [3:0] OP_LOAD = 4'hF;

    // Sub-codes in the aux field
    localparam logic [2:0] MISC_NOP = 3'h0;
    localparam logic [2:0] MISC_SUB_EXIT = 3'h1;
    localparam logic [2:0] MISC_INT_EXIT = 3'h2;
    localparam logic [2:0] MISC_DAA = 3'h3;
    localparam logic [2:0] SKIP_ZERO = 3'h0;
    localparam logic [2:0] SKIP_NONZERO = 3'h1;
    localparam logic [2:0] SKIP_INC_ZERO = 3'h2;
    localparam logic [2:0] SKIP_DEC_ZERO = 3'h3;

    localparam logic [15:0] NOP_INSTR = 16'h0000;

    // Instruction word layout
    typedef struct packed {
        logic [3:0] op;
        logic dest_mem;
        logic [2:0] aux;
        logic [7:0] addr;
    } mis_instr_s;

    // Status flags kept by the ALU
    typedef struct packed {
        logic zero;
        logic carry;
    } mis_flags_s;

    // Four instruction phases
    typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} mis_phase_e;

    // ALU functions
    typedef enum logic [4:0] {
        ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_XOR,
        ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC,
        ALU_DAA, ALU_PASS_M, ALU_PASS_A
    } mis_alu_op_e;

endpackage

// file: core/mis_alu.sv
// Eight-bit ALU of the instruction sequencer
`timescale 1ns/1ps
`default_nettype none

module mis_alu (
    input wire mis_pkg::mis_alu_op_e i_op,
    input wire logic [7:0] i_acc,
    input wire logic [7:0] i_mem,
    input wire mis_pkg::mis_flags_s i_flags,
    output logic [7:0] o_result,
    output mis_pkg::mis_flags_s o_flags
);

    logic [8:0] wide; // Result with carry out
    logic [8:0] adj; // Decimal adjust work value

    // Pure combinational datapath; flag write enables live upstream
    always_comb begin
        wide = {1'b0, i_mem};
        adj = {1'b0, i_acc};
        o_flags = i_flags;
        case (i_op)
            mis_pkg::ALU_ADD: wide = {1'b0, i_acc} + {1'b0, i_mem};
            mis_pkg::ALU_ADC: wide = {1'b0, i_acc} + {1'b0, i_mem}
                + {8'h00, i_flags.carry};
            // Carry set means no borrow
            mis_pkg::ALU_SUB: wide = {1'b0, i_acc} + {1'b0, ~i_mem}
                + 9'h001;
            mis_pkg::ALU_SBC: wide = {1'b0, i_acc} + {1'b0, ~i_mem}
                + {8'h00, i_flags.carry};
            mis_pkg::ALU_AND: wide = {1'b0, i_acc & i_mem};
            mis_pkg::ALU_OR: wide = {1'b0, i_acc | i_mem};
            mis_pkg::ALU_XOR: wide = {1'b0, i_acc ^ i_mem};
            mis_pkg::ALU_CPL: wide = {1'b0, ~i_mem};
            mis_pkg::ALU_RR: wide = {1'b0, i_mem[0], i_mem[7:1]};
            mis_pkg::ALU_RRC: wide = {i_mem[0], i_flags.carry, i_mem[7:1]};
            mis_pkg::ALU_RL: wide = {1'b0, i_mem[6:0], i_mem[7]};
            mis_pkg::ALU_RLC: wide = {i_mem[7], i_mem[6:0], i_flags.carry};
            mis_pkg::ALU_INC: wide = {1'b0, i_mem + 8'h01};
            mis_pkg::ALU_DEC: wide = {1'b0, i_mem - 8'h01};
            mis_pkg::ALU_DAA: begin
                // Adjust each nibble that left the BCD range
                if (adj[3:0] > 4'h9) begin
                    adj = adj + 9'h006;
                end
                if (adj[8:4] > 5'h09 || i_flags.carry) begin
                    adj = adj + 9'h060;
                end
                wide = {adj[8] | i_flags.carry, adj[7:0]};
            end
            mis_pkg::ALU_PASS_A: wide = {1'b0, i_acc};
            default: wide = {1'b0, i_mem};
        endcase
        o_result = wide[7:0];
        o_flags.zero = (wide[7:0] == 8'h00);
        // Only these functions produce a carry
        case (i_op)
            mis_pkg::ALU_ADD, mis_pkg::ALU_ADC, mis_pkg::ALU_SUB,
            mis_pkg::ALU_SBC, mis_pkg::ALU_RRC, mis_pkg::ALU_RLC,
            mis_pkg::ALU_DAA: o_flags.carry = wide[8];
            default: o_flags.carry = i_flags.carry;
        endcase
    end

endmodule

`default_nettype wire

// file: testbench/mis_sequencer_props.sv
// Port-level assertions for the instruction sequencer
`timescale 1ns/1ps
`default_nettype none
module mis_sequencer_props (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [31:0] o_prdata,
    input wire logic [10:0] o_pmem_addr,
    input wire logic o_int_ack,
    input wire logic o_dmem_we,
    input wire logic [3:0] o_instruction_phase_clocks
);
    // One clock domain, so clocking and disable are shared
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    wire logic [3:0] ph = o_instruction_phase_clocks;
    phase_onehot_a: assert property ($onehot(ph))
        else $error("phase clocks not one-hot");
    // Guarded against the reset edge, where the phase jumps to T1
    phase_rotate_a: assert property (!$past(i_rst) && !$stable(ph)
        |-> ph == {$past(ph[2:0]), $past(ph[3])})
        else $error("phase did not advance by one");
    // Reset itself must be watched, so no disable here
    reset_state_a: assert property (disable iff (1'b0) i_rst
        |=> o_pmem_addr == 11'h000 && ph == 4'h1)
        else $error("reset did not restart at address zero");
    fetch_hold_a: assert property (
        !$past(i_rst) && $changed(o_pmem_addr)
        |=> $stable(o_pmem_addr) [*3])
        else $error("fetch address did not stand four cycles");
    int_vector_a: assert property (o_int_ack
        |-> ##[1:8] o_pmem_addr == 11'h004)
        else $error("interrupt did not fetch the vector");
    ack_pulse_a: assert property (o_int_ack |=> !o_int_ack)
        else $error("acknowledge longer than a cycle");
    store_phase_a: assert property (o_dmem_we |-> ph == 4'h1)
        else $error("data write outside first phase");
    apb_answer_a: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no answer one cycle after setup");
    ready_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("ready held over a cycle");
    slverr_zero_a: assert property (o_pslverr
        |-> o_pready && o_prdata == 32'h0)
        else $error("error answer not clean");
    cover property (o_int_ack);
    cover property (o_pslverr);
    cover property (o_dmem_we);
endmodule
`default_nettype wire

// file: testbench/mis_mem_model.sv
// Program and data memory standing beside the sequencer
`timescale 1ns/1ps
`default_nettype none
module mis_mem_model (
    input wire logic i_clock,
    input wire logic [10:0] i_addr,
    output logic [15:0] o_data,
    input wire logic [7:0] i_daddr,
    input wire logic [7:0] i_dwdata,
    input wire logic i_dwe,
    output logic [7:0] o_drdata
);
    logic [15:0] pmem [2048]; // Loaded by the bench, 2K x 16
    logic [7:0] dmem [256]; // Data space
    // One-cycle synchronous reads; program reads and data reads both take one
    always_ff @(posedge i_clock) begin
        o_data <= pmem[i_addr];
        o_drdata <= dmem[i_daddr];
        if (i_dwe) begin
            dmem[i_daddr] <= i_dwdata;
        end
    end
endmodule
`default_nettype wire

// file: testbench/mis_sequencer_tb.sv
// Self-checking bench for the instruction sequencer
`timescale 1ns/1ps
`default_nettype none
module mis_sequencer_tb;
    logic i_clock = 0, i_rst = 1, psel = 0, pen = 0, pwr = 0, irq = 0, er;
    logic [3:0] pa = 4'h0;
    logic [31:0] pwd = 32'h0, rd, prd;
    logic [7:0] r, da, dw, drd;
    logic [8:0] s;
    logic [10:0] ma;
    logic [15:0] md;
    logic prdy, perr, dwe, ack;
    logic [3:0] phc;
    int n_fail = 0, checks_done = 0, cyc = 0;
    always #5 i_clock = ~i_clock;
    mis_sequencer i_mis_sequencer (.i_clock(i_clock), .i_rst(i_rst),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
        .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
        .o_pmem_addr(ma), .i_pmem_data(md), .o_dmem_addr(da),
        .o_dmem_wdata(dw), .o_dmem_we(dwe), .i_dmem_rdata(drd),
        .i_int_req(irq), .o_int_ack(ack), .o_instruction_phase_clocks(phc));
    mis_mem_model i_mis_mem_model (.i_clock(i_clock), .i_addr(ma),
        .o_data(md), .i_daddr(da), .i_dwdata(dw), .i_dwe(dwe),
        .o_drdata(drd));
    task finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard, well beyond the few hundred cycles used
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            finish_test;
        end
    end
    // APB master: request held until ready is seen at a rising edge
    task apb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clock);
        psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
        @(posedge i_clock) pen <= 1;
        do @(posedge i_clock); while (prdy !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 0;
        pen <= 0;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (e !== g) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Expected status word: acc in [15:8], zero bit1, carry bit0
    function automatic logic [31:0] stat(logic [7:0] a, logic z, logic c);
        return {16'h0, a, 6'h0, z, c};
    endfunction
    initial begin
        void'($urandom(46643));
        r = $urandom() | 8'h01; // Nonzero so the skip is taken
        s = {1'b0, r} + {1'b0, r};
        for (int k = 0; k < 2048; k++) i_mis_mem_model.pmem[k] = 16'h0;
        i_mis_mem_model.pmem[0] = {8'hE0, r}; // acc <= r
        i_mis_mem_model.pmem[1] = 16'hE820; // mem[20] <= acc
        i_mis_mem_model.pmem[2] = 16'h1020; // acc <= acc + mem[20]
        i_mis_mem_model.pmem[3] = 16'hD010; // call 010, pushes 4
        i_mis_mem_model.pmem[4] = 16'hB120; // skip when mem[20] nonzero
        i_mis_mem_model.pmem[5] = 16'hE0FF; // must be skipped
        i_mis_mem_model.pmem[6] = 16'hC008;
        i_mis_mem_model.pmem[8] = 16'hC008; // idle loop
        i_mis_mem_model.pmem[16] = 16'h0100; // subroutine exit
        repeat (16) @(posedge i_clock);
        i_rst <= 0;
        apb(0, 4'h4, 0); chk("ctrl reset", 32'h1, rd);
        apb(1, 4'hC, 32'h5A); chk("unmapped err", 1, er);
        repeat (150) @(posedge i_clock);
        apb(0, 4'h8, 0);
        chk("status", stat(s[7:0], s[7:0] == 0, s[8]),
            rd & 32'hFF03);
        apb(1, 4'h0, 32'h5);
        repeat (60) @(posedge i_clock);
        apb(0, 4'h8, 0);
        chk("pcl jump", stat(8'hFF, s[7:0] == 0, s[8]),
            rd & 32'hFF03);
        irq <= 1;
        apb(1, 4'h4, 32'h3);
        for (int k = 0; k < 40 && ack !== 1'b1; k++) @(negedge i_clock);
        chk("int ack", 1, ack);
        @(posedge i_clock) irq <= 0;
        apb(0, 4'h4, 0); chk("gie cleared", 32'h1, rd);
        repeat (40) @(posedge i_clock);
        finish_test;
    end
endmodule
bind mis_sequencer mis_sequencer_props i_mis_sequencer_props (
    .i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_prdata(o_prdata), .o_pmem_addr(o_pmem_addr), .o_int_ack(o_int_ack),
    .o_dmem_we(o_dmem_we),
    .o_instruction_phase_clocks(o_instruction_phase_clocks));
`default_nettype wire
